//--- verilog/brg_cfg.svh
/*
 * Register indices, field positions, reset values and prescale counts of the
 * serial port bit-rate generator.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef BRG_CFG_SVH
`define BRG_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define BRG_RX_CTRL_IDX       8'h18
`define BRG_TX_CTRL_IDX       8'h98
`define BRG_DIVISOR_IDX       8'h99

// Transmit status and control fields
`define BRG_TXC_CLK_SRC_BIT   7
`define BRG_TXC_NINTH_EN_BIT  6
`define BRG_TXC_TX_EN_BIT     5
`define BRG_TXC_SYNC_BIT      4
`define BRG_TXC_HIGH_SPD_BIT  2
`define BRG_TXC_SHIFT_MT_BIT  1
`define BRG_TXC_NINTH_BIT     0

// Writable bits; bit 3 is unimplemented, bit 1 is live transmitter state
`define BRG_TX_WR_MASK        8'hf5
// Receive control: bits 7..3 stored, bits 2..0 are live receiver state
`define BRG_RX_WR_MASK        8'hf8

// Reset values of the stored bits
`define BRG_TX_CTRL_RESET     8'h00
`define BRG_RX_CTRL_RESET     8'h00
`define BRG_DIVISOR_RESET     8'h00

// Prescale terminal counts: divide by 64, 16 and 4 oscillator cycles
`define BRG_PRESCALE_SLOW_TOP 6'h3f
`define BRG_PRESCALE_FAST_TOP 6'h0f
`define BRG_PRESCALE_SYNC_TOP 6'h03

`endif

//--- verilog/brg_pkg.sv
/*
 * Types shared by the bit-rate generator modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package brg_pkg;

    // Scaling selected by the mode bit and the high-speed select bit
    typedef enum logic [1:0] {
        RATE_ASYNC_SLOW,
        RATE_ASYNC_FAST,
        RATE_SYNC
    } rate_mode_type;

    // Synchronous mode overrides the high-speed select bit
    function automatic rate_mode_type decode_rate_mode(input logic sync, input logic high_speed);
        if (sync) begin
            return RATE_SYNC;
        end
        return high_speed ? RATE_ASYNC_FAST : RATE_ASYNC_SLOW;
    endfunction

endpackage

//--- verilog/brg_prescaler.sv
/*
 * Oscillator prescaler: emits one step every 4, 16 or 64 clock cycles.
 * Assumes clear comes from the same clock domain.
 */
`include "brg_cfg.svh"

module brg_prescaler
    import brg_pkg::*;
#(
    parameter int unsigned CNT_WIDTH = 6
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clear,
    input  rate_mode_type             mode,
    output logic                      pre_tick,
    output logic [CNT_WIDTH-1:0]      count
);

    logic [CNT_WIDTH-1:0] count_r;
    logic [CNT_WIDTH-1:0] count_nxt;
    logic [CNT_WIDTH-1:0] top;

    // Terminal count per scaling
    always_comb begin
        unique case (mode)
            RATE_ASYNC_SLOW: top = CNT_WIDTH'(`BRG_PRESCALE_SLOW_TOP);
            RATE_ASYNC_FAST: top = CNT_WIDTH'(`BRG_PRESCALE_FAST_TOP);
            RATE_SYNC:       top = CNT_WIDTH'(`BRG_PRESCALE_SYNC_TOP);
            default:         top = CNT_WIDTH'(`BRG_PRESCALE_SLOW_TOP);
        endcase
    end

    // Compare with >= so a switch to a shorter scale never overshoots
    assign pre_tick  = !clear && (count_r >= top);
    assign count_nxt = (clear || pre_tick) ? '0 : count_r + 1'b1;
    assign count     = count_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

//--- verilog/brg_timer.sv
/*
 * Free-running reloading timer: counts steps from zero up to top, then wraps.
 * Assumes step and clear come from the same clock domain.
 */
module brg_timer #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 clear,
    input  wire logic                 step,
    input  wire logic [WIDTH-1:0]     top,
    output logic                      wrap,
    output logic [WIDTH-1:0]          count
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    // Wrap on the step that finds the count at the top; clear beats a step
    assign wrap      = step && !clear && (count_r >= top);
    assign count_nxt = (clear || wrap) ? '0 : (step ? count_r + 1'b1 : count_r);
    assign count     = count_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

//--- verilog/usart_baud_rate_generator.sv
/*
 * Serial port bit-rate generator with its three control registers on a
 * classic Wishbone slave.
 * Assumes the receiver and transmitter status inputs run on clk, and a
 * master that holds each request until it sees ack.
 */
`include "brg_cfg.svh"

// Contract
// - A dedicated free-running 8-bit timer, period set by the divisor register.
// - One generator times both asynchronous and synchronous modes.
// - Async, high-speed clear: rate is clock over 64 times divisor plus one.
// - Async, high-speed set: rate is clock over 16 times divisor plus one.
// - Sync mode: rate is clock over 4 times divisor plus one.
// - High-speed select matters only in async mode; ignored in sync mode.
// - Rate ticks only as internal-clock master, never when clocked as slave.
// - Any divisor write clears the timer at once.
// - Divisor is an unsigned 0 to 255 taken straight from the register.
// - High-speed select sits at bit 2 of transmit status and control.
// - Divisor resets to zero, fastest rate until written.
module usart_baud_rate_generator
    import brg_pkg::*;
#(
    parameter int unsigned ADR_WIDTH = 10
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 wb_cyc,
    input  wire logic                 wb_stb,
    input  wire logic                 wb_we,
    input  wire logic [ADR_WIDTH-1:0] wb_adr,
    input  wire logic [3:0]           wb_sel,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack,
    input  wire logic                 rx_framing_error,
    input  wire logic                 rx_overrun_error,
    input  wire logic                 rx_ninth_bit,
    input  wire logic                 tx_shift_empty,
    output logic                      rate_tick,
    output logic                      internal_clock,
    output logic                      sync_mode,
    output logic                      high_speed_select,
    output logic                      clock_source_select,
    output logic      [7:0]           tx_control,
    output logic      [7:0]           rx_control
);

    // Bus state
    logic       ack_r;
    logic [7:0] rd_data_r;

    // Register storage
    logic [7:0] tx_ctrl_r;
    logic [7:0] rx_ctrl_r;
    logic [7:0] divisor_r;
    logic [7:0] tx_ctrl_nxt;
    logic [7:0] rx_ctrl_nxt;
    logic [7:0] divisor_nxt;

    // Generator state
    logic          rate_tick_r;
    logic          pre_tick;
    logic          wrap;
    logic [5:0]    prescale_count;
    logic [7:0]    timer_count;
    rate_mode_type rate_mode;

    // Address decode on the word index; byte address is four times the index
    logic [7:0] reg_index;
    logic       req;
    logic       hit_rx;
    logic       hit_tx;
    logic       hit_div;
    logic       wr_commit;
    logic       tx_wr;
    logic       rx_wr;
    logic       div_wr;
    logic [7:0] rx_read;
    logic [7:0] tx_read;
    logic [7:0] read_mux;

    assign reg_index = wb_adr[9:2];
    assign req       = wb_cyc && wb_stb;
    assign hit_rx    = (reg_index == `BRG_RX_CTRL_IDX);
    assign hit_tx    = (reg_index == `BRG_TX_CTRL_IDX);
    assign hit_div   = (reg_index == `BRG_DIVISOR_IDX);

    // A write lands only at the edge where ack is high, and only on lane 0
    assign wr_commit = req && wb_we && ack_r && wb_sel[0];
    assign tx_wr     = wr_commit && hit_tx;
    assign rx_wr     = wr_commit && hit_rx;
    assign div_wr    = wr_commit && hit_div;

    // Next values of the stored bits; read-only bits never store
    assign tx_ctrl_nxt = tx_wr ? (wb_dat_i[7:0] & `BRG_TX_WR_MASK) : tx_ctrl_r;
    assign rx_ctrl_nxt = rx_wr ? (wb_dat_i[7:0] & `BRG_RX_WR_MASK) : rx_ctrl_r;
    assign divisor_nxt = div_wr ? wb_dat_i[7:0] : divisor_r;

    // Read views: live status bits are merged in, reserved bits read zero
    assign rx_read  = rx_ctrl_r | {5'h00, rx_framing_error, rx_overrun_error, rx_ninth_bit};
    assign tx_read  = tx_ctrl_r | {6'h00, tx_shift_empty, 1'b0};
    // Unmapped addresses still answer, with zero data
    assign read_mux = hit_rx  ? rx_read :
                      hit_tx  ? tx_read :
                      hit_div ? divisor_r : 8'h00;

    // One wait state: ack rises the cycle after the request and drops after
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r     <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            ack_r     <= req && !ack_r;
            rd_data_r <= (req && !ack_r) ? read_mux : rd_data_r;
        end
    end

    assign wb_ack   = ack_r;
    assign wb_dat_o = {24'h000000, rd_data_r};

    // Control registers; the divisor comes up at zero, the fastest rate
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ctrl_r <= `BRG_TX_CTRL_RESET;
            rx_ctrl_r <= `BRG_RX_CTRL_RESET;
            divisor_r <= `BRG_DIVISOR_RESET;
        end else begin
            tx_ctrl_r <= tx_ctrl_nxt;
            rx_ctrl_r <= rx_ctrl_nxt;
            divisor_r <= divisor_nxt;
        end
    end

    // Mode decode for the partner logic and the prescaler
    assign sync_mode           = tx_ctrl_r[`BRG_TXC_SYNC_BIT];
    assign high_speed_select   = tx_ctrl_r[`BRG_TXC_HIGH_SPD_BIT];
    assign clock_source_select = tx_ctrl_r[`BRG_TXC_CLK_SRC_BIT];
    assign tx_control          = tx_read;
    assign rx_control          = rx_read;
    // Sync mode forces the divide-by-4 scale whatever high-speed says
    assign rate_mode           = decode_rate_mode(sync_mode, high_speed_select);
    // Async always uses the internal clock; sync only as master
    assign internal_clock      = !sync_mode || clock_source_select;

    // Prescaler shared by every mode, cleared together with the timer
    brg_prescaler #(
        .CNT_WIDTH (6)
    ) u_prescaler (
        .clk      (clk),
        .rst      (rst),
        .clear    (div_wr),
        .mode     (rate_mode),
        .pre_tick (pre_tick),
        .count    (prescale_count)
    );

    // Divisor-driven timer; a write clears it so the new rate starts at once
    brg_timer #(
        .WIDTH (8)
    ) u_timer (
        .clk   (clk),
        .rst   (rst),
        .clear (div_wr),
        .step  (pre_tick),
        .top   (divisor_r),
        .wrap  (wrap),
        .count (timer_count)
    );

    // The tick is held off as a slave, but the timer keeps running so a
    // later switch back to master resumes without a cold start
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_tick_r <= 1'b0;
        end else begin
            rate_tick_r <= wrap && internal_clock;
        end
    end

    assign rate_tick = rate_tick_r;

    // Helper: clock cycles since the last wrap or clear, and whether the
    // scale stayed put during that span so a period can be checked exactly
    logic [14:0] gap_r;
    logic        mode_stable_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            gap_r         <= 15'h0000;
            mode_stable_r <= 1'b1;
        end else begin
            gap_r         <= (wrap || div_wr) ? 15'h0000 : gap_r + 15'h0001;
            mode_stable_r <= tx_wr ? 1'b0 : ((wrap || div_wr) ? 1'b1 : mode_stable_r);
        end
    end

    property p_timer_bounded;
        @(posedge clk) disable iff (rst)
        timer_count <= divisor_r;
    endproperty
    a_timer_bounded: assert property (p_timer_bounded)
        else $error("Timer count above divisor");

    property p_period_slow;
        @(posedge clk) disable iff (rst)
        (wrap && mode_stable_r && !tx_wr && rate_mode == RATE_ASYNC_SLOW) |->
            gap_r == {1'b0, divisor_r, 6'h3f};
    endproperty
    a_period_slow: assert property (p_period_slow)
        else $error("Slow async period is not 64 times divisor plus one");

    property p_period_fast;
        @(posedge clk) disable iff (rst)
        (wrap && mode_stable_r && !tx_wr && !sync_mode && high_speed_select) |->
            gap_r == {3'h0, divisor_r, 4'hf};
    endproperty
    a_period_fast: assert property (p_period_fast)
        else $error("Fast async period is not 16 times divisor plus one");

    property p_period_sync;
        @(posedge clk) disable iff (rst)
        (wrap && mode_stable_r && !tx_wr && sync_mode) |->
            gap_r == {5'h00, divisor_r, 2'h3};
    endproperty
    a_period_sync: assert property (p_period_sync)
        else $error("Sync period is not 4 times divisor plus one");

    property p_high_speed_ignored;
        @(posedge clk) disable iff (rst)
        (sync_mode && high_speed_select && $stable(tx_ctrl_r)) |-> prescale_count <= 6'h03;
    endproperty
    a_high_speed_ignored: assert property (p_high_speed_ignored)
        else $error("High-speed select changed the sync scale");

    property p_slave_silent;
        @(posedge clk) disable iff (rst)
        !internal_clock |=> !rate_tick;
    endproperty
    a_slave_silent: assert property (p_slave_silent)
        else $error("Rate tick issued while clocked as slave");

    property p_write_clears;
        @(posedge clk) disable iff (rst)
        div_wr |=> (timer_count == 8'h00 && prescale_count == 6'h00) ##1 !wrap;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("Divisor write did not clear the timer");

    property p_divisor_loads;
        @(posedge clk) disable iff (rst)
        div_wr |=> divisor_r == $past(wb_dat_i[7:0]);
    endproperty
    a_divisor_loads: assert property (p_divisor_loads)
        else $error("Divisor did not take the written value");

    property p_high_speed_bit;
        @(posedge clk) disable iff (rst)
        tx_wr |=> high_speed_select == $past(wb_dat_i[2]);
    endproperty
    a_high_speed_bit: assert property (p_high_speed_bit)
        else $error("High-speed select not at bit 2");

    property p_divisor_reset;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> divisor_r == 8'h00 && timer_count == 8'h00;
    endproperty
    a_divisor_reset: assert property (p_divisor_reset)
        else $error("Divisor not zero after reset");

    property p_wrap_reload;
        @(posedge clk) disable iff (rst)
        wrap |-> (pre_tick && timer_count == divisor_r) ##1
            (timer_count == 8'h00 && rate_tick == $past(internal_clock));
    endproperty
    a_wrap_reload: assert property (p_wrap_reload)
        else $error("Timer did not tick and reload at the divisor");

    property p_divisor_holds;
        @(posedge clk) disable iff (rst)
        !div_wr |=> $stable(divisor_r);
    endproperty
    a_divisor_holds: assert property (p_divisor_holds)
        else $error("Divisor changed without a write");

    property p_fast_scale;
        @(posedge clk) disable iff (rst)
        (!sync_mode && high_speed_select && $stable(tx_ctrl_r)) |-> prescale_count <= 6'h0f;
    endproperty
    a_fast_scale: assert property (p_fast_scale)
        else $error("Fast async prescale ran past sixteen");

    property p_tick_single;
        @(posedge clk) disable iff (rst)
        rate_tick |=> !rate_tick;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("Rate tick stood longer than one cycle");

    property p_tick_from_wrap;
        @(posedge clk) disable iff (rst)
        rate_tick |-> $past(wrap);
    endproperty
    a_tick_from_wrap: assert property (p_tick_from_wrap)
        else $error("Rate tick without a timer wrap");

    property p_prescale_single;
        @(posedge clk) disable iff (rst)
        pre_tick |=> !pre_tick;
    endproperty
    a_prescale_single: assert property (p_prescale_single)
        else $error("Prescaler stepped on two cycles in a row");

endmodule

//--- dv/serial_port_model.sv
/*
 * Behavioural stand-in for the port's transmitter and receiver: drives their
 * status lines and counts the bit-rate ticks that both of them would consume.
 * Assumes it runs on the generator's clock and reset.
 */
module serial_port_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rate_tick,
    output logic             rx_framing_error,
    output logic             rx_overrun_error,
    output logic             rx_ninth_bit,
    output logic             tx_shift_empty,
    output logic [15:0]      tick_total
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle transmitter: shift register empty, no receive errors
    initial begin
        {rx_framing_error, rx_overrun_error, rx_ninth_bit, tx_shift_empty} = 4'h1;
    end

    // Non-blocking so a change never races the edge that samples it
    task automatic set_status(input logic [3:0] v);
        {rx_framing_error, rx_overrun_error, rx_ninth_bit, tx_shift_empty} <= v;
    endtask

    // One tick times transmitter and receiver alike
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_total <= 16'h0000;
        end else if (rate_tick) begin
            tick_total <= tick_total + 16'h0001;
        end
    end
endmodule

//--- dv/usart_baud_rate_generator_tb.sv
/*
 * Self-checking bench of the bit-rate generator: register access over classic
 * Wishbone, tick spacing in every scaling mode, slave gating.
 * Assumes the design files and the serial port model are compiled first.
 */
module usart_baud_rate_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [9:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        rx_framing_error, rx_overrun_error, rx_ninth_bit, tx_shift_empty;
    logic        rate_tick, internal_clock, sync_mode, high_speed_select, clock_source_select;
    logic [7:0]  tx_control, rx_control;
    logic [15:0] tick_total;
    int          error_cnt, checks_done;

    usart_baud_rate_generator #(.ADR_WIDTH(10)) uut (
        .clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack(wb_ack), .rx_framing_error(rx_framing_error), .rx_overrun_error(rx_overrun_error),
        .rx_ninth_bit(rx_ninth_bit), .tx_shift_empty(tx_shift_empty), .rate_tick(rate_tick),
        .internal_clock(internal_clock), .sync_mode(sync_mode), .high_speed_select(high_speed_select),
        .clock_source_select(clock_source_select), .tx_control(tx_control), .rx_control(rx_control));

    serial_port_model partner (
        .clk(clk), .rst(rst), .rate_tick(rate_tick), .rx_framing_error(rx_framing_error),
        .rx_overrun_error(rx_overrun_error), .rx_ninth_bit(rx_ninth_bit),
        .tx_shift_empty(tx_shift_empty), .tick_total(tick_total));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled at an edge
    task automatic bus(input logic we, input logic [9:0] adr, input logic [7:0] dat, input logic [3:0] sel);
        int n;
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} <= {2'b11, we, adr, sel, 24'h0, dat};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wb_ack === 1'b1) break;
        end
        if (n == 20) chk("wb_ack", 1, 0);
        rd = wb_dat_o;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask

    task automatic t_reset;
        bus(0, 10'h264, 8'h00, 4'h1); chk("divisor reset", 32'h0, rd);
        bus(0, 10'h260, 8'h00, 4'h1); chk("tx ctrl reset", 32'h2, rd);
        chk("internal_clock reset", 1, internal_clock);
        $display("test reset done");
    endtask

    task automatic t_regs;
        bus(1, 10'h260, 8'hff, 4'h1);
        bus(0, 10'h260, 8'h00, 4'h1); chk("tx ctrl all ones", 32'hf7, rd);
        chk("tx_control", 32'hf7, tx_control);
        chk("mode outputs", 3'b111, {sync_mode, high_speed_select, clock_source_select});
        bus(1, 10'h260, 8'h04, 4'h1);
        bus(0, 10'h260, 8'h00, 4'h1); chk("tx ctrl high speed", 32'h06, rd);
        chk("high_speed_select", 2'b01, {sync_mode, high_speed_select});
        partner.set_status(4'ha);
        bus(1, 10'h060, 8'hff, 4'h1);
        bus(0, 10'h060, 8'h00, 4'h1); chk("rx ctrl", 32'hfd, rd);
        chk("rx_control", 32'hfd, rx_control);
        chk("tx_control live", 32'h04, tx_control);
        bus(1, 10'h264, 8'ha5, 4'h1);
        bus(1, 10'h264, 8'h5a, 4'h0);
        bus(1, 10'h3fc, 8'h33, 4'h1);
        bus(0, 10'h264, 8'h00, 4'h1); chk("divisor value", 32'ha5, rd);
        bus(0, 10'h3fc, 8'h00, 4'h1); chk("unmapped read", 32'h0, rd);
        partner.set_status(4'h1);
        $display("test registers done");
    endtask

    // Slave clocking: timer runs but no tick leaves
    task automatic t_slave;
        logic [15:0] t0;
        bus(1, 10'h260, 8'h10, 4'h1);
        bus(1, 10'h264, 8'h00, 4'h1);
        t0 = tick_total;
        repeat (300) @(posedge clk);
        chk("slave ticks", t0, tick_total);
        chk("internal_clock slave", 0, internal_clock);
        $display("test slave done");
    endtask

    // Latency from the divisor commit edge, then the steady period
    task automatic t_rate(input logic sync, input logic hs, input logic [7:0] x, input int p);
        int n;
        bus(1, 10'h260, 8'h80 | {3'b0, sync, 4'h0} | {5'b0, hs, 2'b0}, 4'h1);
        bus(1, 10'h264, x, 4'h1);
        for (n = 1; n < 5000; n++) begin
            @(posedge clk);
            if (rate_tick === 1'b1) break;
        end
        chk("first tick", p * (x + 1) + 1, n);
        for (n = 1; n < 5000; n++) begin
            @(posedge clk);
            if (rate_tick === 1'b1) break;
        end
        chk("tick period", p * (x + 1), n);
        $display("test rate sync=%0d hs=%0d x=%0d done", sync, hs, x);
    endtask

    // Reset in mid-run: divisor back to zero, first slow tick 65 edges on
    task automatic t_midreset;
        int n;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (n = 1; n < 5000; n++) begin
            @(posedge clk);
            if (rate_tick === 1'b1) break;
        end
        chk("tick after reset", 65, n);
        bus(0, 10'h264, 8'h00, 4'h1); chk("divisor after reset", 32'h0, rd);
        $display("test mid-run reset done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset for 10 cycles, then the scenarios
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_slave;
        t_rate(0, 0, 8'h00, 64);
        t_rate(0, 0, 8'h01, 64);
        t_rate(0, 1, 8'h03, 16);
        t_rate(1, 0, 8'h02, 4);
        t_rate(1, 1, 8'h02, 4);
        t_rate(1, 0, 8'hff, 4);
        t_rate(0, 1, 8'hff, 16);
        t_midreset;
        results;
    end

    // Whole run is about 11000 cycles; this leaves wide margin
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen hang");
        results;
    end
endmodule
